// file: dv/cpu_exec_model.sv
// execute-side partner model that issues stack requests and waits for completion
`timescale 1ns/1ps
module cpu_exec_model (
  // clock
  input  wire logic        clk_sys_i,
  // stack request side
  output logic             stk_req_o,
  output logic [3:0]       stk_op_o,
  output logic [7:0]       stk_data_o,
  output logic [15:0]      stk_pc_o,
  output logic [7:0]       stk_uptr_o,
  // completion side
  input  wire logic        stk_busy_i,
  input  wire logic        stk_done_i
);
  initial begin
    stk_req_o  = 1'b0;
    stk_op_o   = 4'h0;
    stk_data_o = 8'h00;
    stk_pc_o   = 16'h0000;
    stk_uptr_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one request at a time; data held past the request since it is sampled late
  task automatic run(input logic [3:0] op, input logic [7:0] d, input logic [15:0] pc,
                     input logic [7:0] up, output int n, output int b);
    @(posedge clk_sys_i);
    stk_req_o  <= 1'b1;
    stk_op_o   <= op;
    stk_data_o <= d;
    stk_pc_o   <= pc;
    stk_uptr_o <= up;
    @(posedge clk_sys_i);
    stk_req_o  <= 1'b0;
    // the edge that takes the request counts as the first cycle
    n = 1;
    b = 0;
    // bounded wait so a stuck sequencer shows as a wrong count, not a hang
    while (n < 20) begin
      @(posedge clk_sys_i);
      n++;
      #1;
      if (stk_busy_i === 1'b1) b++;
      if (stk_done_i === 1'b1) break;
    end
  endtask : run
endmodule : cpu_exec_model

// file: dv/test_working_register_address_and_stack.sv
// self-checking bench for working-register addressing and stack handling
`timescale 1ns/1ps
module test_working_register_address_and_stack;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata;
  logic        opnd_valid = 1'b0;
  logic [7:0]  opnd      = 8'h00;
  logic        opnd_short = 1'b0;
  logic [2:0]  opnd_mode = 3'h0;
  logic [7:0]  opnd_addr, opnd_value, stk_data_in, stk_uptr_in, stk_data, stk_flags, stk_uptr, sp_top;
  logic        opnd_is_wreg, opnd_bad, stk_req, stk_busy, stk_done;
  logic [3:0]  stk_op;
  logic [15:0] stk_pc_in, stk_pc;
  logic [7:0]  v, e;
  int          error_cnt = 0;
  int          n_tests   = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  working_register_address_and_stack uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .opnd_valid_i(opnd_valid),
    .opnd_i(opnd), .opnd_short_i(opnd_short), .opnd_mode_i(opnd_mode), .opnd_addr_o(opnd_addr),
    .opnd_value_o(opnd_value), .opnd_is_wreg_o(opnd_is_wreg), .opnd_bad_mode_o(opnd_bad),
    .stk_req_i(stk_req), .stk_op_i(stk_op), .stk_data_i(stk_data_in), .stk_pc_i(stk_pc_in),
    .stk_uptr_i(stk_uptr_in), .stk_busy_o(stk_busy), .stk_done_o(stk_done), .stk_data_o(stk_data),
    .stk_pc_o(stk_pc), .stk_flags_o(stk_flags), .stk_uptr_o(stk_uptr), .stack_top_pointer_o(sp_top));

  cpu_exec_model cpu (
    .clk_sys_i(clk_sys_i), .stk_req_o(stk_req), .stk_op_o(stk_op), .stk_data_o(stk_data_in),
    .stk_pc_o(stk_pc_in), .stk_uptr_o(stk_uptr_in), .stk_busy_i(stk_busy), .stk_done_i(stk_done));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys_i);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data is only valid in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_i);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rchk

  task automatic op(input logic [7:0] o, input logic s, input logic [2:0] m);
    @(posedge clk_sys_i);
    opnd_valid <= 1'b1;
    opnd       <= o;
    opnd_short <= s;
    opnd_mode  <= m;
    @(posedge clk_sys_i);
    opnd_valid <= 1'b0;
    #1;
  endtask : op

  task automatic sop(input logic [3:0] o, input logic [7:0] d, input logic [15:0] pc,
                     input logic [7:0] up, input int lat);
    int n;
    int b;
    cpu.run(o, d, pc, up, n, b);
    chk(16'(n), 16'(lat));
    chk(16'(b), 16'(lat - 2));
  endtask : sop

  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rchk(wreg_stack_pkg::slice_pointer_first_addr, 8'hc0);
    rchk(wreg_stack_pkg::slice_pointer_second_addr, 8'hc8);
    for (int i = 0; i < 16; i++) begin
      op({4'h3, 4'(i)}, 1'b1, 3'h0);
      chk({8'h00, opnd_addr}, {8'h00, 8'hc0 + 8'(i)});
    end
    // pointer low bits set on purpose: they must not leak into the address
    wr(wreg_stack_pkg::slice_pointer_first_addr, 8'h77);
    wr(wreg_stack_pkg::slice_pointer_second_addr, 8'had);
    rchk(wreg_stack_pkg::slice_pointer_first_addr, 8'h77);
    for (int i = 0; i < 16; i++) begin
      // slice bases of the two pointers with their low bits dropped
      e = (i[3] ? 8'ha8 : 8'h70) | 8'(i % 8);
      wr(e, e ^ 8'h3c);
      op({4'hc, 4'(i)}, 1'b0, 3'h0);
      chk({8'h00, opnd_addr}, {8'h00, e});
      chk({8'h00, opnd_value}, {8'h00, e ^ 8'h3c});
      chk({14'h0, opnd_is_wreg, opnd_bad}, 16'h0002);
      op({4'h9, 4'(i)}, 1'b1, 3'h0);
      chk({8'h00, opnd_addr}, {8'h00, e});
    end
    wr(8'h40, 8'h99);
    for (int m = 0; m < 8; m++) begin
      op(8'h40, 1'b0, 3'(m));
      chk({15'h0, opnd_bad}, {15'h0, m == 7});
    end
    op(8'h40, 1'b0, 3'h0);
    chk({opnd_addr, opnd_value}, 16'h4099);
    chk({15'h0, opnd_is_wreg}, 16'h0000);
    wr(wreg_stack_pkg::stack_pointer_byte_addr, 8'hff);
    sop(4'h1, 8'h11, 16'h0, 8'h0, 3);
    sop(4'h1, 8'h22, 16'h0, 8'h0, 3);
    rchk(wreg_stack_pkg::stack_pointer_byte_addr, 8'hfd);
    chk({8'h00, sp_top}, 16'h00fd);
    rchk(8'hfe, 8'h11);
    rchk(8'hfd, 8'h22);
    sop(4'h2, 8'h00, 16'h0, 8'h0, 3);
    chk({stk_data, sp_top}, 16'h22fe);
    sop(4'h2, 8'h00, 16'h0, 8'h0, 3);
    chk({stk_data, sp_top}, 16'h11ff);
    sop(4'h3, 8'h00, 16'h1234, 8'h0, 4);
    chk({8'h00, sp_top}, 16'h00fd);
    rchk(8'hfe, 8'h34);
    rchk(8'hfd, 8'h12);
    sop(4'h4, 8'h00, 16'h0, 8'h0, 4);
    chk(stk_pc, 16'h1234);
    wr(wreg_stack_pkg::flags_addr, 8'h5a);
    sop(4'h5, 8'h00, 16'hbeef, 8'h0, 5);
    chk({8'h00, sp_top}, 16'h00fc);
    rchk(8'hfc, 8'h5a);
    wr(wreg_stack_pkg::flags_addr, 8'h00);
    sop(4'h6, 8'h00, 16'h0, 8'h0, 5);
    chk(stk_pc, 16'hbeef);
    chk({stk_flags, sp_top}, 16'h5aff);
    rchk(wreg_stack_pkg::flags_addr, 8'h5a);
    sop(4'h7, 8'h66, 16'h0, 8'h40, 3);
    chk({stk_uptr, sp_top}, 16'h41ff);
    rchk(8'h41, 8'h66);
    sop(4'h8, 8'h77, 16'h0, 8'h50, 3);
    chk({stk_uptr, sp_top}, 16'h4fff);
    rchk(8'h4f, 8'h77);
    sop(4'h9, 8'h00, 16'h0, 8'h41, 3);
    chk({stk_data, stk_uptr}, 16'h6642);
    sop(4'ha, 8'h00, 16'h0, 8'h4f, 3);
    chk({stk_data, stk_uptr}, 16'h774e);
    chk({8'h00, sp_top}, 16'h00ff);
    end_of_test();
  end
endmodule : test_working_register_address_and_stack

// file: hdl/working_register_address_and_stack.sv
// working-register address formation, register file and stack sequencer
// What this block does
// - 4-bit operand msb picks first (0) or second (1) slice pointer
// - upper five bits of chosen pointer form upper five address bits
// - operand low three bits fill the address low bits
// - 8-bit operand with upper nibble 1100b resolves as a 4-bit operand
// - in 8-bit working addressing bit 3 picks the pointer
// - push decrements stack pointer first, then writes the byte
// - pop reads at stack pointer, then increments it
// - stack pointer always addresses most recently pushed entry
// - call pushes program counter, return reloads it
// - interrupt pushes counter and flags, interrupt return pops both
// - stack pointer is one byte at d9h, stack lives in register file
// - stack pointer has no defined value after reset
// - four user-stack push/pop forms using any register as pointer
// - register mode reads the named single register byte as operand
// - seven operand addressing modes are supported
// - slice pointers live at d6h and d7h, writable
// - after reset pointers select c0h-c7h and c8h-cfh
`timescale 1ns/1ps
module working_register_address_and_stack #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_i,
  // register port
  input  wire logic [7:0]                      reg_addr_i,
  input  wire logic [7:0]                      reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output logic      [7:0]                      reg_rdata_o,
  // operand resolution
  input  wire logic                            opnd_valid_i,
  input  wire logic [7:0]                      opnd_i,
  input  wire logic                            opnd_short_i,
  input  wire logic [2:0]                      opnd_mode_i,
  output logic      [7:0]                      opnd_addr_o,
  output logic      [7:0]                      opnd_value_o,
  output logic                                 opnd_is_wreg_o,
  output logic                                 opnd_bad_mode_o,
  // stack requests
  input  wire logic                            stk_req_i,
  input  wire logic [3:0]                      stk_op_i,
  input  wire logic [7:0]                      stk_data_i,
  input  wire logic [15:0]                     stk_pc_i,
  input  wire logic [7:0]                      stk_uptr_i,
  output logic                                 stk_busy_o,
  output logic                                 stk_done_o,
  output logic      [7:0]                      stk_data_o,
  output logic      [15:0]                     stk_pc_o,
  output logic      [7:0]                      stk_flags_o,
  output logic      [7:0]                      stk_uptr_o,
  output logic      [7:0]                      stack_top_pointer_o
);
  if (DATA_W != 8) begin : g_width_check
    $error("register file is byte wide only");
  end

  ////////////////////////////////////////////////////////////////////
  // register file: slice pointers live inside it, stack pointer is a separate register mapped at d9h
  logic [7:0] rf      [256];
  logic [7:0] next_rf [256];
  logic [7:0] stack_top_pointer;
  logic [7:0] next_stack_top_pointer;
  wreg_stack_pkg::seq_state_t state, next_state;
  wreg_stack_pkg::stack_op_t  op, next_op;
  logic [7:0]  tmp_ptr, next_tmp_ptr;
  logic [15:0] pc_hold, next_pc_hold;
  logic [7:0]  data_hold, next_data_hold;
  logic [7:0]  flags_hold, next_flags_hold;
  logic        done, next_done;
  logic        busy, next_busy;
  logic [7:0]  rdata, next_rdata;
  logic [7:0]  waddr;
  logic [7:0]  wdata;
  logic        wen;

  wire logic [7:0] slice_pointer_first  = rf[wreg_stack_pkg::slice_pointer_first_addr];
  wire logic [7:0] slice_pointer_second = rf[wreg_stack_pkg::slice_pointer_second_addr];

  ////////////////////////////////////////////////////////////////////
  // operand address formation
  logic [7:0] next_opnd_addr;
  logic [7:0] next_opnd_value;
  logic       next_opnd_is_wreg;
  logic       next_opnd_bad;
  logic [7:0] opnd_addr, opnd_value;
  logic       opnd_is_wreg, opnd_bad;

  always_comb begin
    logic [3:0] nib;
    logic [7:0] ptr;
    logic       wreg;
    nib  = opnd_i[3:0];
    wreg = opnd_short_i || (opnd_i[7:4] == wreg_stack_pkg::wreg_prefix);
    ptr  = nib[3] ? slice_pointer_second : slice_pointer_first;
    next_opnd_is_wreg = wreg;
    if (wreg) begin
      // low pointer bits dropped so a misaligned pointer still hits its slice
      next_opnd_addr = {ptr[7:3], nib[2:0]};
    end else begin
      next_opnd_addr = opnd_i;
    end
    next_opnd_value = rf[next_opnd_addr];
    // a 1100b field always resolves through a pointer, so only the mode can be bad
    next_opnd_bad = (opnd_mode_i > 3'h6);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      opnd_addr    <= 8'h00;
      opnd_value   <= 8'h00;
      opnd_is_wreg <= 1'b0;
      opnd_bad     <= 1'b0;
    end else if (opnd_valid_i) begin
      opnd_addr    <= next_opnd_addr;
      opnd_value   <= next_opnd_value;
      opnd_is_wreg <= next_opnd_is_wreg;
      opnd_bad     <= next_opnd_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stack sequencer: one byte moved per cycle
  always_comb begin
    next_state      = state;
    next_op         = op;
    next_tmp_ptr    = tmp_ptr;
    next_pc_hold    = pc_hold;
    next_data_hold  = data_hold;
    next_flags_hold = flags_hold;
    next_done       = 1'b0;
    wen             = 1'b0;
    waddr           = 8'h00;
    wdata           = 8'h00;
    next_stack_top_pointer = stack_top_pointer;
    unique case (state)
      wreg_stack_pkg::st_idle: begin
        if (stk_req_i) begin
          next_op      = wreg_stack_pkg::stack_op_t'(stk_op_i);
          next_tmp_ptr = stk_uptr_i;
          next_pc_hold = stk_pc_i;
          next_state   = wreg_stack_pkg::st_step1;
        end else if (reg_wr_i) begin
          wen   = 1'b1;
          waddr = reg_addr_i;
          wdata = reg_wdata_i;
        end
      end
      wreg_stack_pkg::st_step1: begin
        next_state = wreg_stack_pkg::st_done;
        unique case (op)
          wreg_stack_pkg::op_push: begin
            next_stack_top_pointer = stack_top_pointer - 8'h01;
            wen   = 1'b1;
            waddr = stack_top_pointer - 8'h01;
            wdata = stk_data_i;
          end
          wreg_stack_pkg::op_pop: begin
            next_data_hold         = rf[stack_top_pointer];
            next_stack_top_pointer = stack_top_pointer + 8'h01;
          end
          wreg_stack_pkg::op_call, wreg_stack_pkg::op_intr: begin
            // low byte first so the high byte ends nearest the top
            next_stack_top_pointer = stack_top_pointer - 8'h01;
            wen   = 1'b1;
            waddr = stack_top_pointer - 8'h01;
            wdata = pc_hold[7:0];
            next_state = wreg_stack_pkg::st_step2;
          end
          wreg_stack_pkg::op_ret, wreg_stack_pkg::op_interrupt_return: begin
            if (op == wreg_stack_pkg::op_interrupt_return) begin
              next_flags_hold = rf[stack_top_pointer];
              // flags go back to their home register as well as the port
              wen   = 1'b1;
              waddr = wreg_stack_pkg::flags_addr;
              wdata = rf[stack_top_pointer];
              next_stack_top_pointer = stack_top_pointer + 8'h01;
              next_state = wreg_stack_pkg::st_step2;
            end else begin
              next_pc_hold[15:8] = rf[stack_top_pointer];
              next_stack_top_pointer = stack_top_pointer + 8'h01;
              next_state = wreg_stack_pkg::st_step3;
            end
          end
          wreg_stack_pkg::op_upush_inc, wreg_stack_pkg::op_upush_dec: begin
            next_tmp_ptr = (op == wreg_stack_pkg::op_upush_inc) ? tmp_ptr + 8'h01 : tmp_ptr - 8'h01;
            wen   = 1'b1;
            waddr = next_tmp_ptr;
            wdata = stk_data_i;
          end
          wreg_stack_pkg::op_upop_inc, wreg_stack_pkg::op_upop_dec: begin
            next_data_hold = rf[tmp_ptr];
            next_tmp_ptr = (op == wreg_stack_pkg::op_upop_inc) ? tmp_ptr + 8'h01 : tmp_ptr - 8'h01;
          end
          default: ;
        endcase
      end
      wreg_stack_pkg::st_step2: begin
        next_state = wreg_stack_pkg::st_step3;
        if (op == wreg_stack_pkg::op_interrupt_return) begin
          next_pc_hold[15:8] = rf[stack_top_pointer];
          next_stack_top_pointer = stack_top_pointer + 8'h01;
        end else begin
          next_stack_top_pointer = stack_top_pointer - 8'h01;
          wen   = 1'b1;
          waddr = stack_top_pointer - 8'h01;
          wdata = pc_hold[15:8];
          if (op == wreg_stack_pkg::op_call) next_state = wreg_stack_pkg::st_done;
        end
      end
      wreg_stack_pkg::st_step3: begin
        next_state = wreg_stack_pkg::st_done;
        if (op == wreg_stack_pkg::op_intr) begin
          next_stack_top_pointer = stack_top_pointer - 8'h01;
          wen   = 1'b1;
          waddr = stack_top_pointer - 8'h01;
          wdata = rf[wreg_stack_pkg::flags_addr];
        end else begin
          next_pc_hold[7:0] = rf[stack_top_pointer];
          next_stack_top_pointer = stack_top_pointer + 8'h01;
        end
      end
      wreg_stack_pkg::st_done: begin
        next_done  = 1'b1;
        next_state = wreg_stack_pkg::st_idle;
      end
      default: next_state = wreg_stack_pkg::st_idle;
    endcase
    // the pointer byte is shadowed so the sequencer and software agree
    if (wen && waddr == wreg_stack_pkg::stack_pointer_byte_addr) next_stack_top_pointer = wdata;
    next_busy = (next_state != wreg_stack_pkg::st_idle);
    next_rdata = reg_rd_i ? ((reg_addr_i == wreg_stack_pkg::stack_pointer_byte_addr) ?
                             stack_top_pointer : rf[reg_addr_i]) : 8'h00;
  end

  always_comb begin
    for (int i = 0; i < 256; i++) begin
      next_rf[i] = (wen && waddr == 8'(i)) ? wdata : rf[i];
    end
  end

  // stack pointer left out of reset on purpose
  always_ff @(posedge clk_sys_i) begin
    stack_top_pointer <= next_stack_top_pointer;
    rf                <= next_rf;
    if (rst_i) begin
      rf[wreg_stack_pkg::slice_pointer_first_addr]  <= wreg_stack_pkg::slice_pointer_first_rst;
      rf[wreg_stack_pkg::slice_pointer_second_addr] <= wreg_stack_pkg::slice_pointer_second_rst;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state      <= wreg_stack_pkg::st_idle;
      op         <= wreg_stack_pkg::op_none;
      tmp_ptr    <= 8'h00;
      pc_hold    <= 16'h0000;
      data_hold  <= 8'h00;
      flags_hold <= 8'h00;
      done       <= 1'b0;
      rdata      <= 8'h00;
      busy       <= 1'b0;
    end else begin
      state      <= next_state;
      op         <= next_op;
      tmp_ptr    <= next_tmp_ptr;
      pc_hold    <= next_pc_hold;
      data_hold  <= next_data_hold;
      flags_hold <= next_flags_hold;
      done       <= next_done;
      rdata      <= next_rdata;
      busy       <= next_busy;
    end
  end

  assign reg_rdata_o         = rdata;
  assign opnd_addr_o         = opnd_addr;
  assign opnd_value_o        = opnd_value;
  assign opnd_is_wreg_o      = opnd_is_wreg;
  assign opnd_bad_mode_o     = opnd_bad;
  assign stk_busy_o          = busy;
  assign stk_done_o          = done;
  assign stk_data_o          = data_hold;
  assign stk_pc_o            = pc_hold;
  assign stk_flags_o         = flags_hold;
  assign stk_uptr_o          = tmp_ptr;
  assign stack_top_pointer_o = stack_top_pointer;

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence push_step;
    state == wreg_stack_pkg::st_step1 && op == wreg_stack_pkg::op_push;
  endsequence

  a_push_predec: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    push_step |=> stack_top_pointer == $past(stack_top_pointer) - 8'h01 && rf[stack_top_pointer] == $past(stk_data_i))
    else $error("push did not predecrement and store");
  a_pop_postinc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == wreg_stack_pkg::st_step1 && op == wreg_stack_pkg::op_pop |=>
      data_hold == $past(rf[stack_top_pointer]) && stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("pop did not read then increment");
  a_wreg_short: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    opnd_valid_i && opnd_short_i && !opnd_i[3] |=> opnd_addr[7:3] == $past(slice_pointer_first[7:3]))
    else $error("short operand used wrong pointer");
  a_wreg_long: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    opnd_valid_i && opnd_i[7:4] == 4'hc && opnd_i[3] |=> opnd_addr == {$past(slice_pointer_second[7:3]), $past(opnd_i[2:0])})
    else $error("long working operand misformed");
  a_ptr_reset: assert property (@(posedge clk_sys_i)
    rst_i |=> slice_pointer_first == 8'hc0 && slice_pointer_second == 8'hc8)
    else $error("pointers not at common area after reset");
  a_call_depth: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == wreg_stack_pkg::st_idle && stk_req_i && stk_op_i == 4'h3 |-> ##4 stk_done_o)
    else $error("call did not finish in four cycles");
  a_intr_three: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == wreg_stack_pkg::st_idle && stk_req_i && stk_op_i == 4'h5 |=> ##3 stack_top_pointer == $past(stack_top_pointer, 4) - 8'h03)
    else $error("interrupt did not push three bytes");
  a_common_wreg: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    opnd_valid_i && !opnd_short_i && opnd_mode_i == 3'h0 && opnd_i[7:4] == 4'hc |=> opnd_is_wreg && !opnd_bad)
    else $error("1100b operand not resolved as working register");
endmodule : working_register_address_and_stack

// file: hdl/wreg_stack_pkg.sv
// constants for working-register address formation and stack handling
package wreg_stack_pkg;
  localparam logic [7:0] slice_pointer_first_addr  = 8'hd6;
  localparam logic [7:0] slice_pointer_second_addr = 8'hd7;
  localparam logic [7:0] stack_pointer_byte_addr   = 8'hd9;
  localparam logic [7:0] flags_addr                = 8'hd5;
  localparam logic [7:0] slice_pointer_first_rst   = 8'hc0;
  localparam logic [7:0] slice_pointer_second_rst  = 8'hc8;
  localparam logic [3:0] wreg_prefix               = 4'hc;
  localparam logic [7:0] stack_pointer_seed        = 8'h00;
  localparam int         ptr_hi_bits               = 5;
  localparam int         slice_bits                = 3;

  // addressing modes
  typedef enum logic [2:0] {
    mode_reg      = 3'h0,
    mode_ind_reg  = 3'h1,
    mode_indexed  = 3'h2,
    mode_direct   = 3'h3,
    mode_ind_addr = 3'h4,
    mode_relative = 3'h5,
    mode_immed    = 3'h6
  } addr_mode_t;

  // stack operation kinds
  typedef enum logic [3:0] {
    op_none      = 4'h0,
    op_push      = 4'h1,
    op_pop       = 4'h2,
    op_call      = 4'h3,
    op_ret       = 4'h4,
    op_intr      = 4'h5,
    op_interrupt_return      = 4'h6,
    op_upush_inc = 4'h7,
    op_upush_dec = 4'h8,
    op_upop_inc  = 4'h9,
    op_upop_dec  = 4'ha
  } stack_op_t;

  // sequencer states, gray along interrupt and interrupt-return path up to done
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_step1 = 3'b001,
    st_step2 = 3'b011,
    st_step3 = 3'b010,
    st_done  = 3'b110
  } seq_state_t;
endpackage : wreg_stack_pkg
